// ===== src/srh_ctrl.sv
// Summary of operation
// RL1 - Memory is static; controller issues no refresh or clocked strobes.
// RL2 - Read: strobe high, select low, address picks one of 16,384 bits.
// RL3 - Read data valid one access time after address or select change.
// RL4 - Data pin may be indeterminate early; sample only after access time.
// RL5 - Output floats when deselected or writing; drives only in read.
// RL6 - Write when strobe and select both low; starts at later edge.
// RL7 - Select or strobe high whenever the address lines change.
// RL8 - Address held stable for the whole write cycle.
// RL9 - Falling strobe floats the output within the float delay.
// RL10 - Access equals cycle time; new address each access time.
// RL11 - Chip-select variant gives fast select access; no power saving.
// RL12 - Enable high puts the chip-enable variant into standby.
// RL13 - 14-bit address, separate one-bit data in and data out.
`timescale 1ns/100ps
`default_nettype none
`include "srh_params.svh"
module srh_ctrl #(
    parameter int ACCESS_CYC = `SRH_ACCESS_CYC,
    parameter int WPULSE_CYC = `SRH_WPULSE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_req_valid,
    input wire srh_pkg::srh_req_t i_req,
    output logic o_req_ready,
    output logic o_rdata_valid,
    output logic o_rdata,
    output logic o_wdone,
    output srh_pkg::srh_pins_t o_pins,
    input wire logic i_dout
);
    import srh_pkg::*;

    // Last count of each timed phase. The read phase runs two cycles past
    // the access time: the bit that leaves the synchroniser must have been
    // taken strictly after the access time, since the pins themselves leave
    // flip-flops a little after the clock edge.
    localparam int RD_LAST = ACCESS_CYC + 2;
    localparam int WR_LAST = WPULSE_CYC - 1;
    // Read phase ends with the answer pulse and select rising together
    // Counter just wide enough for the longer phase, with one spare bit
    localparam int CMAX = (RD_LAST > WR_LAST) ? RD_LAST : WR_LAST;
    localparam int CW = $clog2(CMAX + 1) + 1;

    // Sequencer state
    srh_state_t state_r, state_nxt;
    // Pin flip-flops toward the memory
    srh_pins_t pins_r, pins_nxt;
    // Cycle counter of the timed phases
    logic [CW-1:0] cnt_r, cnt_nxt;
    // Answer pulses and the held read bit
    logic rv_r, rv_nxt;
    logic rd_r, rd_nxt;
    logic wd_r, wd_nxt;
    // Synchroniser stages of the data pin
    logic dout_s1_r, dout_s1_nxt;
    logic dout_s2_r, dout_s2_nxt;

    // True on the last counted cycle of a timed phase
    function automatic logic phase_done(input logic [CW-1:0] cnt,
        input int last);
        // Cast keeps the compare at the counter's width
        phase_done = (cnt == CW'(last));
    endfunction

    // Next values of the synchroniser; the data pin is asynchronous to
    // the clock, so nothing but the second stage is read further on
    always_comb
    begin
        dout_s1_nxt = i_dout;
        dout_s2_nxt = dout_s1_r;
    end

    // Synchroniser stages; frozen with the rest while the enable is low
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            // Reset level is arbitrary; no read takes it before refill
            dout_s1_r <= 1'h0;
            dout_s2_r <= 1'h0;
        end
        else if (i_ce)
        begin
            dout_s1_r <= dout_s1_nxt;
            dout_s2_r <= dout_s2_nxt;
        end
    end

    // Ready only while idle; a request seen while busy is not stored
    assign o_req_ready = (state_r == SRH_IDLE);
    // Pins and answers leave straight from flip-flops
    assign o_pins = pins_r;
    assign o_rdata_valid = rv_r;
    assign o_rdata = rd_r;
    assign o_wdone = wd_r;

    // Next-state logic of the access sequencer. Pins keep their value
    // unless a state moves them, so address and data stand through every
    // phase; the answer pulses fall back to low after one cycle.
    always_comb
    begin
        state_nxt = state_r;
        pins_nxt = pins_r;
        cnt_nxt = cnt_r;
        rv_nxt = 1'h0;
        rd_nxt = rd_r;
        wd_nxt = 1'h0;
        // One branch per phase of an access
        case (state_r)
            SRH_IDLE:
            begin
                // Select and strobe both high here, so address may move;
                // select high between accesses also lets an enable-type
                // memory drop into standby
                pins_nxt.sel_n = 1'h1; // see RL12
                pins_nxt.wstb_n = 1'h1;
                if (i_req_valid)
                begin
                    // Address and data go out a cycle before any control
                    pins_nxt.word_select_lines = i_req.addr; // see RL7
                    pins_nxt.din = i_req.wdata; // see RL13
                    cnt_nxt = '0;
                    state_nxt = i_req.write ? SRH_WSET : SRH_RSET;
                end
            end
            SRH_RSET:
            begin
                // Address already stable, so select may fall now; the
                // access is then counted from the select edge
                pins_nxt.sel_n = 1'h0; // see RL2 RL11
                state_nxt = SRH_RWAIT;
            end
            SRH_RWAIT:
            begin
                // The data pin may show anything until the access time has
                // passed; wait it out plus the synchroniser delay
                if (phase_done(cnt_r, RD_LAST))
                begin
                    rv_nxt = 1'h1; // see RL4
                    rd_nxt = dout_s2_r; // see RL3
                    // Select rises; the next address may follow at once
                    pins_nxt.sel_n = 1'h1; // see RL10
                    state_nxt = SRH_IDLE;
                end
                else
                begin
                    // Count the cycles of the access
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            SRH_WSET:
            begin
                // Strobe and select fall together; write starts here and
                // the output never gets to drive during the write
                pins_nxt.sel_n = 1'h0; // see RL6
                pins_nxt.wstb_n = 1'h0; // see RL9
                cnt_nxt = '0;
                state_nxt = SRH_WPULSE;
            end
            SRH_WPULSE:
            begin
                // Address and data held through the pulse
                if (phase_done(cnt_r, WR_LAST))
                begin
                    // Strobe rises first and ends the write
                    pins_nxt.wstb_n = 1'h1; // see RL8
                    state_nxt = SRH_WEND;
                end
                else
                begin
                    // Count the cycles of the pulse
                    cnt_nxt = cnt_r + CW'(1);
                end
            end
            SRH_WEND:
            begin
                // Select rises with the address still held, closing the
                // cycle; the output floats again once deselected
                pins_nxt.sel_n = 1'h1; // see RL5
                wd_nxt = 1'h1;
                state_nxt = SRH_IDLE;
            end
            default:
            begin
                // Unused codes park the pins in the deselected state
                state_nxt = SRH_IDLE;
                pins_nxt.sel_n = 1'h1;
                pins_nxt.wstb_n = 1'h1;
            end
        endcase
    end

    // Registers of the sequencer; pins are flops, no clock goes out and
    // the memory never needs a refresh cycle from this side.
    // Enable low freezes every flop, so the pins stand exactly as they
    // were and the memory sees no edge while frozen.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_r <= SRH_IDLE;
            pins_r <= '{sel_n: 1'h1, wstb_n: 1'h1,
                word_select_lines: 14'h0000, din: 1'h0}; // see RL1
            cnt_r <= '0;
            rv_r <= 1'h0;
            rd_r <= 1'h0;
            wd_r <= 1'h0;
        end
        else if (i_ce)
        begin
            // Enable high: every register takes its next value
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            cnt_r <= cnt_nxt;
            rv_r <= rv_nxt;
            rd_r <= rd_nxt;
            wd_r <= wd_nxt;
        end
    end
endmodule // srh_ctrl
`default_nettype wire

// ===== src/srh_params.svh
`ifndef SRH_PARAMS_SVH
`define SRH_PARAMS_SVH
// Pin widths and memory depth
`define SRH_ADDR_W 14
`define SRH_DEPTH 16384
// Timing figures in ns (fastest grade) and the clock period in ns
`define SRH_CLK_PERIOD_NS 10
`define SRH_T_ACCESS_NS 20
`define SRH_T_FLOAT_NS 8
`define SRH_T_DSETUP_NS 10
`define SRH_T_WPULSE_NS 16
// Least times round up to whole cycles; a zero time gives zero cycles
`define SRH_CEIL(t) (((t) + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_ACCESS_CYC `SRH_CEIL(`SRH_T_ACCESS_NS)
`define SRH_FLOAT_CYC `SRH_CEIL(`SRH_T_FLOAT_NS)
`define SRH_WPULSE_CYC `SRH_CEIL(`SRH_T_WPULSE_NS)
`endif

// ===== src/srh_pkg.sv
package srh_pkg;
    typedef enum logic [2:0] {
        SRH_IDLE = 3'b000,
        SRH_RSET = 3'b001,
        SRH_RWAIT = 3'b010,
        SRH_WSET = 3'b011,
        SRH_WPULSE = 3'b100,
        SRH_WEND = 3'b101
    } srh_state_t;

    // Request from the user side
    typedef struct packed {
        logic write;
        logic [13:0] addr;
        logic wdata;
    } srh_req_t;

    // Pins driven toward the memory
    typedef struct packed {
        logic sel_n;
        logic wstb_n;
        logic [13:0] word_select_lines;
        logic din;
    } srh_pins_t;
endpackage

// ===== tb/srh_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module srh_ctrl_bench;
    import srh_pkg::*;
    localparam int AC = 2;
    localparam int WP = 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vld = 1'b0;
    logic ce = 1'h1;
    srh_req_t req = '0;
    logic rdy, rv, rd, wd, dout;
    srh_pins_t pins;
    int failures = 0;
    int check_count = 0;
    int cyc = 0;
    srh_ctrl #(.ACCESS_CYC(AC), .WPULSE_CYC(WP)) dut_u (.i_sys_clk(clk),
        .i_rst(rst), .i_ce(ce), .i_req_valid(vld), .i_req(req),
        .o_req_ready(rdy), .o_rdata_valid(rv), .o_rdata(rd),
        .o_wdone(wd), .o_pins(pins), .i_dout(dout));
    srh_mem_model mem_u (.i_sel_n(pins.sel_n), .i_wstb_n(pins.wstb_n),
        .i_addr(pins.word_select_lines), .i_din(pins.din), .o_dout(dout));
    // Compare and count
    task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
        check_count++;
        if (e !== s)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One request; bad keeps a stray write asserted while busy
    task automatic op(logic w, logic [13:0] a, logic d, logic bad,
        output logic [7:0] n);
        @(posedge clk) #1;
        chk("ready", 8'h01, {7'h00, rdy});
        vld = 1'b1;
        req = '{w, a, d};
        @(posedge clk) #1;
        chk("busy", 8'h00, {7'h00, rdy});
        vld = bad;
        req = '{1'b1, 14'h3FFF, 1'b0};
        n = 8'h01;
        while (rv !== 1'b1 && wd !== 1'b1 && n < 8'h14)
        begin
            @(posedge clk) #1;
            n++;
        end
        vld = 1'b0;
        chk("answered", 8'h01, {7'h00, rv | wd});
    endtask
    // Boundary addresses, latencies and data
    task automatic s_fill;
        logic [7:0] n;
        op(1'b1, 14'h0000, 1'b1, 1'b0, n);
        chk("write time", 8'(WP + 3), n);
        op(1'b1, 14'h3FFF, 1'b0, 1'b0, n);
        op(1'b0, 14'h0000, 1'b0, 1'b0, n);
        chk("read time", 8'(AC + 5), n);
        chk("read low", 8'h01, {7'h00, rd});
        op(1'b0, 14'h3FFF, 1'b0, 1'b0, n);
        chk("read high", 8'h00, {7'h00, rd});
    endtask
    // Back-to-back overwrite, then a refused stray write
    task automatic s_over;
        logic [7:0] n;
        op(1'b1, 14'h3FFF, 1'b1, 1'b0, n);
        op(1'b0, 14'h3FFF, 1'b0, 1'b1, n);
        chk("overwrite", 8'h01, {7'h00, rd});
        op(1'b0, 14'h3FFF, 1'b0, 1'b0, n);
        chk("refused", 8'h01, {7'h00, rd});
    endtask
    // Enable low: a request must wait, pins must not move
    task automatic s_freeze;
        logic [7:0] n;
        @(posedge clk) #1;
        ce = 1'h0;
        vld = 1'h1;
        req = '{1'h0, 14'h0000, 1'h0};
        repeat (3) @(posedge clk);
        #1;
        chk("frozen sel", 8'h01, {7'h00, pins.sel_n});
        chk("frozen ready", 8'h01, {7'h00, rdy});
        vld = 1'h0;
        ce = 1'h1;
        op(1'h0, 14'h0000, 1'h0, 1'h0, n);
        chk("thaw read", 8'h01, {7'h00, rd});
    endtask
    task automatic close_out;
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            failures++;
            close_out;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        s_fill;
        s_over;
        s_freeze;
        close_out;
    end
endmodule // srh_ctrl_bench
`default_nettype wire

// ===== tb/srh_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module srh_ctrl_checker #(
    parameter int ACCESS_CYC = 2,
    parameter int WPULSE_CYC = 2
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_req_valid,
    input wire srh_pkg::srh_req_t i_req,
    input wire logic o_req_ready,
    input wire logic o_rdata_valid,
    input wire logic o_wdone,
    input wire srh_pkg::srh_pins_t o_pins
);
    import srh_pkg::*;
    localparam int RD_LAT = ACCESS_CYC + 5;
    localparam int WR_LAT = WPULSE_CYC + 3;
    logic tk;
    // Request taken this edge
    assign tk = i_ce && i_req_valid && o_req_ready;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    rd_lat_a: assert property (tk && !i_req.write |-> ##RD_LAT o_rdata_valid)
        else $error("read answer late");
    wr_lat_a: assert property (tk && i_req.write |-> ##WR_LAT o_wdone)
        else $error("write answer late");
    addr_hold_a: assert property (!$stable(o_pins.word_select_lines) |-> o_pins.sel_n && $past(o_pins.sel_n))
        else $error("address moved while selected");
    din_hold_a: assert property (!o_pins.wstb_n |-> $stable(o_pins.din) && $stable(o_pins.word_select_lines))
        else $error("pins moved in write");
    wr_sel_a: assert property (!o_pins.wstb_n |-> !o_pins.sel_n)
        else $error("strobe without select");
    wr_pulse_a: assert property ($fell(o_pins.wstb_n) |-> $fell(o_pins.sel_n) ##0 (!o_pins.wstb_n)[*2] ##1 o_pins.wstb_n)
        else $error("bad strobe pulse");
    idle_sel_a: assert property (o_req_ready |-> o_pins.sel_n && o_pins.wstb_n)
        else $error("selected while idle");
    rd_win_a: assert property (o_rdata_valid |-> !$past(o_pins.sel_n) && !$past(o_pins.sel_n, 5))
        else $error("read sampled early");
endmodule // srh_ctrl_checker
bind srh_ctrl srh_ctrl_checker #(.ACCESS_CYC(ACCESS_CYC),
    .WPULSE_CYC(WPULSE_CYC)) chk_u (.i_sys_clk, .i_rst, .i_ce,
    .i_req_valid, .i_req, .o_req_ready, .o_rdata_valid, .o_wdone, .o_pins);
`default_nettype wire

// ===== tb/srh_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module srh_mem_model (
    input wire logic i_sel_n,
    input wire logic i_wstb_n,
    input wire logic [13:0] i_addr,
    input wire logic i_din,
    output var logic o_dout
);
    logic mem [16384]; // Static store
    int gen = 0;
    int due = 0;
    // Bit lands as the strobe rises under select
    always @(posedge i_wstb_n)
        if (!i_sel_n) mem[i_addr] = i_din;
    // Any select, strobe or address change shows the inverse and restarts the access time
    initial o_dout = 1'b0;
    always @(i_sel_n, i_wstb_n, i_addr)
    begin
        o_dout = ~o_dout;
        gen = gen + 1;
        due <= #20 gen;
    end
    // Data shows only if nothing moved since and the pins say read
    always @(due)
        if (due == gen && !i_sel_n && i_wstb_n)
            o_dout = mem[i_addr];
endmodule // srh_mem_model
`default_nettype wire
